/* design/mfc_pkg.sv */
// constants and field layout of the frame control register bank
// Operation
// - feature control register changes only while receive and transmit MACs are both off
// - feature control bits 15:9 reserved; register resets to all zeros
// - control bit 8 lets the receiver accept frames under 64 bytes
// - control bit 7 lets the receiver accept broadcast frames
// - control bit 6 drops received pause frames inside the MAC
// - control bit 5 selects transmit half duplex, only at 10/100 speed
// - control bit 4 accepts multicast via hash filter; clear rejects all but pause
// - control bit 3 signals received pause frames to transmitter, regardless of drop
// - control bit 2 stops the transmitter appending the frame check sequence
// - control bit 1 strips FCS and pad before the receive FIFO
// - pad stripping acts only when length/type carries a length
// - control bit 0 is promiscuous: no address filtering at all
// - frame length limit resets to 1518; longer received frames flagged long
// - frame length limit changes only while the MAC is disabled
// - gap field is 5 bits of byte times, resets to 12, bits 15:5 reserved
// - MAC is disabled only when transmit and receive enables are both low
// - each 16-bit register is two bytes, lower address is the lower byte
package mfc_pkg;

  // byte addresses on the host interface
  localparam logic [7:0] MFC_ADDR_CTL_LO   = 8'h02;
  localparam logic [7:0] MFC_ADDR_CTL_HI   = 8'h03;
  localparam logic [7:0] MFC_ADDR_LIMIT_LO = 8'h04;
  localparam logic [7:0] MFC_ADDR_LIMIT_HI = 8'h05;
  localparam logic [7:0] MFC_ADDR_GAP_LO   = 8'h08;
  localparam logic [7:0] MFC_ADDR_GAP_HI   = 8'h09;

  // reset values and writable masks
  localparam logic [15:0] MFC_CTL_RESET   = 16'h0000;
  localparam logic [15:0] MFC_CTL_MASK    = 16'h01FF;
  localparam logic [15:0] MFC_LIMIT_RESET = 16'h05EE;
  localparam logic [15:0] MFC_LIMIT_MASK  = 16'hFFFF;
  localparam logic [15:0] MFC_GAP_RESET   = 16'h000C;
  localparam logic [15:0] MFC_GAP_MASK    = 16'h001F;

  // feature control bit positions
  localparam int MFC_BIT_SHORT   = 8;
  localparam int MFC_BIT_BCAST   = 7;
  localparam int MFC_BIT_DROP    = 6;
  localparam int MFC_BIT_HDX     = 5;
  localparam int MFC_BIT_MCAST   = 4;
  localparam int MFC_BIT_PAUSE   = 3;
  localparam int MFC_BIT_NO_FCS  = 2;
  localparam int MFC_BIT_STRIP   = 1;
  localparam int MFC_BIT_PROMISC = 0;

  // gap field width
  localparam int MFC_GAP_W = 5;

  // frame geometry in bytes
  localparam logic [15:0] MFC_MIN_FRAME   = 16'h0040;
  localparam logic [15:0] MFC_FCS_BYTES   = 16'h0004;
  localparam logic [15:0] MFC_HDR_BYTES   = 16'h000E;
  localparam logic [15:0] MFC_LEN_MAX     = 16'h05DC;
  localparam logic [15:0] MFC_MIN_PAYLOAD = 16'h002E;

endpackage

/* design/mfc_host_reg.sv */
// one 16-bit host register written a byte at a time
`timescale 1ns/1ps
module mfc_host_reg
  import mfc_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK   = 16'hFFFF
) (
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // byte write port
  input  wire logic        wr_en_in,
  input  wire logic        lane_hi_in,
  input  wire logic [7:0]  wdata_in,
  // stored value
  output logic      [15:0] value_out
);

  typedef struct packed {
    logic [15:0] value;
  } mfc_hreg_state_t;

  mfc_hreg_state_t state_reg;
  mfc_hreg_state_t state_next;

  // byte lane merge; reserved bits never store so they read zero
  always_comb begin
    state_next = state_reg;
    if (wr_en_in) begin
      if (lane_hi_in) begin
        state_next.value[15:8] = wdata_in & WR_MASK[15:8];
      end else begin
        state_next.value[7:0] = wdata_in & WR_MASK[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg.value <= RESET_VAL;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value_out = state_reg.value;

endmodule

/* design/mfc_gap_timer.sv */
// idle byte-time counter between transmitted frames
`timescale 1ns/1ps
module mfc_gap_timer
  import mfc_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_in,
  // transmit timing
  input  wire logic                 frame_end_in,
  input  wire logic                 byte_tick_in,
  input  wire logic [MFC_GAP_W-1:0] gap_in,
  // gap satisfied
  output logic                      gap_done_out
);

  typedef struct packed {
    logic [MFC_GAP_W-1:0] count;
    logic                 done;
  } mfc_gap_state_t;

  mfc_gap_state_t state_reg;
  mfc_gap_state_t state_next;

  // restart at each frame end, count byte times until the gap is met
  always_comb begin
    state_next = state_reg;
    if (frame_end_in) begin
      state_next.count = '0;
      state_next.done  = (gap_in == '0);
    end else if (!state_reg.done && byte_tick_in) begin
      state_next.count = state_reg.count + 1'b1;
      state_next.done  = ((state_reg.count + 1'b1) >= gap_in);
    end
  end

  // idle link after reset: gap already satisfied
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg.count <= '0;
      state_reg.done  <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign gap_done_out = state_reg.done;

endmodule

/* design/mac_frame_control_registers.sv */
// frame control register bank with receive decision and transmit gap logic
`timescale 1ns/1ps
module mac_frame_control_registers
  import mfc_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  // byte-wide host interface
  input  wire logic        hi_cs_in,
  input  wire logic        hi_wr_in,
  input  wire logic        hi_rd_in,
  input  wire logic [7:0]  hi_addr_in,
  input  wire logic [7:0]  hi_wdata_in,
  output logic      [7:0]  hi_rdata_out,
  output logic             hi_rdy_out,
  output logic             hi_wr_ignored_out,
  // mode register state
  input  wire logic        tx_en_in,
  input  wire logic        rx_en_in,
  input  wire logic        gbit_en_in,
  // received frame summary
  input  wire logic        rx_frame_end_in,
  input  wire logic [15:0] rx_byte_count_in,
  input  wire logic [15:0] rx_len_type_in,
  input  wire logic        rx_bcast_in,
  input  wire logic        rx_mcast_in,
  input  wire logic        rx_addr_match_in,
  input  wire logic        rx_hash_hit_in,
  input  wire logic        rx_pause_in,
  // receive decision
  output logic             rx_done_out,
  output logic             rx_accept_out,
  output logic             rx_long_out,
  output logic             rx_short_out,
  output logic [15:0]      rx_keep_bytes_out,
  output logic             rx_pause_ind_out,
  // transmit control
  input  wire logic        tx_frame_end_in,
  input  wire logic        tx_byte_tick_in,
  output logic             tx_gap_ok_out,
  output logic             tx_half_duplex_out,
  output logic             tx_append_fcs_out,
  // live configuration
  output logic [15:0]      feature_ctl_out,
  output logic [15:0]      frame_limit_out
);

  typedef struct packed {
    logic [7:0]  rdata;
    logic        rdy;
    logic        wr_ignored;
    logic        rx_done;
    logic        rx_accept;
    logic        rx_long;
    logic        rx_short;
    logic [15:0] rx_keep;
    logic        rx_pause_ind;
    logic        tx_gap_ok;
    logic        tx_hdx;
    logic        tx_fcs;
    logic [15:0] ctl;
    logic [15:0] limit;
  } mfc_top_state_t;

  mfc_top_state_t state_reg;
  mfc_top_state_t state_next;

  logic        mac_idle;
  logic        wr_strobe;
  logic        wr_allowed;
  logic        wr_ctl;
  logic        wr_limit;
  logic        wr_gap;
  logic        lane_hi;
  logic [15:0] frame_feature_control;
  logic [15:0] frame_length_limit;
  logic [15:0] interframe_gap_length;
  logic        gap_done;

  // disabled only when both mode enables are low
  assign mac_idle   = !tx_en_in && !rx_en_in;
  assign wr_strobe  = hi_cs_in && hi_wr_in;
  // protected registers take writes only while idle
  assign wr_allowed = wr_strobe && mac_idle;
  assign lane_hi    = hi_addr_in[0];

  // address decode per register
  assign wr_ctl   = wr_allowed && (hi_addr_in == MFC_ADDR_CTL_LO || hi_addr_in == MFC_ADDR_CTL_HI);
  assign wr_limit = wr_allowed && (hi_addr_in == MFC_ADDR_LIMIT_LO || hi_addr_in == MFC_ADDR_LIMIT_HI);
  assign wr_gap   = wr_allowed && (hi_addr_in == MFC_ADDR_GAP_LO || hi_addr_in == MFC_ADDR_GAP_HI);

  // feature control, reserved 15:9 held at zero
  mfc_host_reg #(
    .RESET_VAL (MFC_CTL_RESET),
    .WR_MASK   (MFC_CTL_MASK)
  ) u_ctl_reg (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_en_in   (wr_ctl),
    .lane_hi_in (lane_hi),
    .wdata_in   (hi_wdata_in),
    .value_out  (frame_feature_control)
  );

  // frame length limit
  mfc_host_reg #(
    .RESET_VAL (MFC_LIMIT_RESET),
    .WR_MASK   (MFC_LIMIT_MASK)
  ) u_limit_reg (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_en_in   (wr_limit),
    .lane_hi_in (lane_hi),
    .wdata_in   (hi_wdata_in),
    .value_out  (frame_length_limit)
  );

  // inter-packet gap, five useful bits
  mfc_host_reg #(
    .RESET_VAL (MFC_GAP_RESET),
    .WR_MASK   (MFC_GAP_MASK)
  ) u_gap_reg (
    .clk_sys_in (clk_sys_in),
    .rst_in     (rst_in),
    .wr_en_in   (wr_gap),
    .lane_hi_in (lane_hi),
    .wdata_in   (hi_wdata_in),
    .value_out  (interframe_gap_length)
  );

  // transmit idle spacing in byte times
  mfc_gap_timer u_gap_timer (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .frame_end_in (tx_frame_end_in),
    .byte_tick_in (tx_byte_tick_in),
    .gap_in       (interframe_gap_length[MFC_GAP_W-1:0]),
    .gap_done_out (gap_done)
  );

  // next state: host answers, receive verdict, transmit controls
  always_comb begin
    logic        addr_ok;
    logic        mcast_ok;
    logic        size_ok;
    logic        is_length;
    logic [15:0] pad_bytes;
    logic [15:0] keep;
    addr_ok   = 1'b0;
    mcast_ok  = 1'b0;
    size_ok   = 1'b0;
    is_length = 1'b0;
    pad_bytes = '0;
    keep      = '0;
    state_next = state_reg;

    // host read data and ready, one cycle after the strobe
    state_next.rdy        = hi_cs_in && (hi_wr_in || hi_rd_in);
    state_next.wr_ignored = wr_strobe && !mac_idle &&
                            (hi_addr_in >= MFC_ADDR_CTL_LO && hi_addr_in <= MFC_ADDR_GAP_HI);
    if (hi_cs_in && hi_rd_in) begin
      case (hi_addr_in)
        MFC_ADDR_CTL_LO: begin
          state_next.rdata = frame_feature_control[7:0];
        end
        MFC_ADDR_CTL_HI: begin
          state_next.rdata = frame_feature_control[15:8];
        end
        MFC_ADDR_LIMIT_LO: begin
          state_next.rdata = frame_length_limit[7:0];
        end
        MFC_ADDR_LIMIT_HI: begin
          state_next.rdata = frame_length_limit[15:8];
        end
        MFC_ADDR_GAP_LO: begin
          state_next.rdata = interframe_gap_length[7:0];
        end
        MFC_ADDR_GAP_HI: begin
          state_next.rdata = interframe_gap_length[15:8];
        end
        default: begin
          state_next.rdata = 8'h00;
        end
      endcase
    end

    // multicast: hash filter if enabled, pause always passes
    mcast_ok = rx_mcast_in && !rx_bcast_in &&
               ((frame_feature_control[MFC_BIT_MCAST] && rx_hash_hit_in) || rx_pause_in);
    // promiscuous bypasses every address test
    addr_ok  = frame_feature_control[MFC_BIT_PROMISC] || rx_addr_match_in ||
               (rx_bcast_in && frame_feature_control[MFC_BIT_BCAST]) ||
               mcast_ok;
    // short frames only with the short enable
    size_ok  = (rx_byte_count_in >= MFC_MIN_FRAME) || frame_feature_control[MFC_BIT_SHORT];
    // pad only exists on length-coded frames
    is_length = (rx_len_type_in <= MFC_LEN_MAX);
    if (is_length && rx_len_type_in < MFC_MIN_PAYLOAD) begin
      pad_bytes = MFC_MIN_PAYLOAD - rx_len_type_in;
    end

    // bytes written to the client fifo
    keep = rx_byte_count_in;
    if (frame_feature_control[MFC_BIT_STRIP]) begin
      if (rx_byte_count_in >= MFC_FCS_BYTES) begin
        keep = rx_byte_count_in - MFC_FCS_BYTES;
      end else begin
        keep = '0;
      end
      if (is_length && keep >= pad_bytes) begin
        keep = keep - pad_bytes;
      end
    end

    // done and pause indication pulse once per received frame; the verdict flags hold until the next frame end
    state_next.rx_done      = rx_frame_end_in;
    state_next.rx_pause_ind = 1'b0;
    if (rx_frame_end_in) begin
      state_next.rx_accept = addr_ok && size_ok &&
                             !(rx_pause_in && frame_feature_control[MFC_BIT_DROP]);
      state_next.rx_long   = (rx_byte_count_in > frame_length_limit);
      state_next.rx_short  = (rx_byte_count_in < MFC_MIN_FRAME);
      state_next.rx_keep   = keep;
      // pause indication ignores the drop setting
      state_next.rx_pause_ind = rx_pause_in && frame_feature_control[MFC_BIT_PAUSE];
    end

    // transmit side controls, registered so outputs come from flops
    state_next.tx_gap_ok = gap_done;
    state_next.tx_hdx    = frame_feature_control[MFC_BIT_HDX] && !gbit_en_in;
    state_next.tx_fcs    = !frame_feature_control[MFC_BIT_NO_FCS];
    state_next.ctl       = frame_feature_control;
    state_next.limit     = frame_length_limit;
  end

  // reset to documented values; fcs appended and gap met while idle
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg.rdata        <= 8'h00;
      state_reg.rdy          <= 1'b0;
      state_reg.wr_ignored   <= 1'b0;
      state_reg.rx_done      <= 1'b0;
      state_reg.rx_accept    <= 1'b0;
      state_reg.rx_long      <= 1'b0;
      state_reg.rx_short     <= 1'b0;
      state_reg.rx_keep      <= 16'h0000;
      state_reg.rx_pause_ind <= 1'b0;
      state_reg.tx_gap_ok    <= 1'b1;
      state_reg.tx_hdx       <= 1'b0;
      state_reg.tx_fcs       <= 1'b1;
      state_reg.ctl          <= MFC_CTL_RESET;
      state_reg.limit        <= MFC_LIMIT_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state flops
  assign hi_rdata_out       = state_reg.rdata;
  assign hi_rdy_out         = state_reg.rdy;
  assign hi_wr_ignored_out  = state_reg.wr_ignored;
  assign rx_done_out        = state_reg.rx_done;
  assign rx_accept_out      = state_reg.rx_accept;
  assign rx_long_out        = state_reg.rx_long;
  assign rx_short_out       = state_reg.rx_short;
  assign rx_keep_bytes_out  = state_reg.rx_keep;
  assign rx_pause_ind_out   = state_reg.rx_pause_ind;
  assign tx_gap_ok_out      = state_reg.tx_gap_ok;
  assign tx_half_duplex_out = state_reg.tx_hdx;
  assign tx_append_fcs_out  = state_reg.tx_fcs;
  assign feature_ctl_out    = state_reg.ctl;
  assign frame_limit_out    = state_reg.limit;

endmodule

/* test/mfc_monitor.sv */
// assertion checker for the frame control register bank
`timescale 1ns/1ps
module mfc_monitor
  import mfc_pkg::*;
(
  // host side
  input wire logic        clk_sys_in,
  input wire logic        rst_in,
  input wire logic        hi_cs_in,
  input wire logic        hi_wr_in,
  input wire logic        hi_rd_in,
  input wire logic [7:0]  hi_addr_in,
  input wire logic [7:0]  hi_wdata_in,
  input wire logic        hi_rdy_out,
  input wire logic        hi_wr_ignored_out,
  input wire logic        tx_en_in,
  input wire logic        rx_en_in,
  input wire logic        gbit_en_in,
  // frame side
  input wire logic        rx_frame_end_in,
  input wire logic [15:0] rx_byte_count_in,
  input wire logic        rx_pause_in,
  input wire logic        rx_done_out,
  input wire logic        rx_accept_out,
  input wire logic        rx_long_out,
  input wire logic        rx_pause_ind_out,
  input wire logic        tx_byte_tick_in,
  input wire logic        tx_gap_ok_out,
  input wire logic        tx_half_duplex_out,
  input wire logic        tx_append_fcs_out,
  input wire logic [15:0] feature_ctl_out,
  input wire logic [15:0] frame_limit_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  // request and protected-write helpers
  wire logic req = hi_cs_in & (hi_wr_in | hi_rd_in);
  wire logic on  = tx_en_in | rx_en_in;
  wire logic prot = (hi_addr_in >= MFC_ADDR_CTL_LO) && (hi_addr_in <= MFC_ADDR_GAP_HI);
  property p_rdy; req |=> hi_rdy_out; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after access");
  property p_no_rdy; !req |=> !hi_rdy_out; endproperty
  a_no_rdy: assert property (p_no_rdy) else $error("stray ready");
  property p_refuse; hi_cs_in && hi_wr_in && on && prot |=> hi_wr_ignored_out; endproperty
  a_refuse: assert property (p_refuse) else $error("enabled write not refused");
  property p_ign_cause; hi_wr_ignored_out |-> $past(hi_cs_in && hi_wr_in && on); endproperty
  a_ign_cause: assert property (p_ign_cause) else $error("refusal without enabled write");
  property p_ctl_lo;
    hi_cs_in && hi_wr_in && !on && hi_addr_in == MFC_ADDR_CTL_LO |=> ##1 feature_ctl_out[7:0] == $past(hi_wdata_in, 2);
  endproperty
  a_ctl_lo: assert property (p_ctl_lo) else $error("control low byte not stored");
  property p_rsvd; feature_ctl_out[15:9] == 7'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved control bits set");
  property p_long; rx_frame_end_in |=> rx_done_out && rx_long_out == ($past(rx_byte_count_in) > frame_limit_out); endproperty
  a_long: assert property (p_long) else $error("long flag wrong");
  property p_short;
    rx_frame_end_in && rx_byte_count_in < MFC_MIN_FRAME && !feature_ctl_out[MFC_BIT_SHORT] |=> !rx_accept_out;
  endproperty
  a_short: assert property (p_short) else $error("short frame accepted");
  property p_pause; rx_frame_end_in |=> rx_pause_ind_out == $past(rx_pause_in && feature_ctl_out[MFC_BIT_PAUSE]); endproperty
  a_pause: assert property (p_pause) else $error("pause signal wrong");
  property p_hdx; tx_half_duplex_out == (feature_ctl_out[MFC_BIT_HDX] && !$past(gbit_en_in)); endproperty
  a_hdx: assert property (p_hdx) else $error("half duplex wrong");
  property p_fcs; tx_append_fcs_out == !feature_ctl_out[MFC_BIT_NO_FCS]; endproperty
  a_fcs: assert property (p_fcs) else $error("fcs append wrong");
  property p_gap; $rose(tx_gap_ok_out) |-> $past(tx_byte_tick_in, 2); endproperty
  a_gap: assert property (p_gap) else $error("gap ended without tick");
endmodule
bind mac_frame_control_registers mfc_monitor mfc_monitor_i (.*);

/* test/mfc_host_model.sv */
// host processor model on the byte-wide host interface
`timescale 1ns/1ps
module mfc_host_model (
  // clock
  input  wire logic       clk_sys_in,
  // bus drive
  output logic            hi_cs_out,
  output logic            hi_wr_out,
  output logic            hi_rd_out,
  output logic [7:0]      hi_addr_out,
  output logic [7:0]      hi_wdata_out,
  // device answer
  input  wire logic       hi_rdy_in,
  input  wire logic [7:0] hi_rdata_in,
  input  wire logic       hi_wr_ignored_in
);
  // idle bus
  initial begin
    hi_cs_out = 1'b0;
    hi_wr_out = 1'b0;
    hi_rd_out = 1'b0;
    hi_addr_out = 8'h00;
    hi_wdata_out = 8'h00;
  end
  // one byte access; held over the taking edge only, longer would start a second access
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic ok, output logic ign);
    @(negedge clk_sys_in);
    hi_cs_out = 1'b1;
    hi_wr_out = w;
    hi_rd_out = !w;
    hi_addr_out = a;
    hi_wdata_out = d;
    @(negedge clk_sys_in);
    hi_cs_out = 1'b0;
    hi_wr_out = 1'b0;
    hi_rd_out = 1'b0;
    hi_addr_out = ~a; // released lines show no stale value
    hi_wdata_out = ~d;
    ok = hi_rdy_in;
    q = hi_rdata_in;
    ign = hi_wr_ignored_in;
  endtask
endmodule

/* test/mac_frame_control_registers_tb_top.sv */
// self-checking bench for the frame control register bank
`timescale 1ns/1ps
module mac_frame_control_registers_tb_top;
  import mfc_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        cs, wr, rd, rdy, ign, tx_en, rx_en, gbit, fe, bc, mc, am, hh, pz, tfe, tick;
  logic        done, acc, lng, shrt, pind, gok, hdx, fcs;
  logic [7:0]  addr, wdata, rdata;
  logic [15:0] cnt, lt, keep, fctl, flim;
  int          n_mismatch = 0;
  int          n_checks = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  mac_frame_control_registers mac_frame_control_registers_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .hi_cs_in(cs), .hi_wr_in(wr), .hi_rd_in(rd), .hi_addr_in(addr), .hi_wdata_in(wdata), .hi_rdata_out(rdata),
    .hi_rdy_out(rdy), .hi_wr_ignored_out(ign), .tx_en_in(tx_en), .rx_en_in(rx_en), .gbit_en_in(gbit),
    .rx_frame_end_in(fe), .rx_byte_count_in(cnt), .rx_len_type_in(lt), .rx_bcast_in(bc), .rx_mcast_in(mc),
    .rx_addr_match_in(am), .rx_hash_hit_in(hh), .rx_pause_in(pz), .rx_done_out(done), .rx_accept_out(acc),
    .rx_long_out(lng), .rx_short_out(shrt), .rx_keep_bytes_out(keep), .rx_pause_ind_out(pind),
    .tx_frame_end_in(tfe), .tx_byte_tick_in(tick), .tx_gap_ok_out(gok), .tx_half_duplex_out(hdx),
    .tx_append_fcs_out(fcs), .feature_ctl_out(fctl), .frame_limit_out(flim));
  mfc_host_model mfc_host_model_i (.clk_sys_in(clk_sys_in), .hi_cs_out(cs), .hi_wr_out(wr), .hi_rd_out(rd),
    .hi_addr_out(addr), .hi_wdata_out(wdata), .hi_rdy_in(rdy), .hi_rdata_in(rdata), .hi_wr_ignored_in(ign));
  // compare and count
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // byte read and write, answer checked on the host side
  task automatic rdb(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    logic ok, ig;
    mfc_host_model_i.acc(1'b0, a, 8'h00, q, ok, ig);
    chk("read ready", 16'h0001, {15'h0000, ok});
    chk("read byte", {8'h00, e}, {8'h00, q});
  endtask
  task automatic wrb(input logic [7:0] a, input logic [7:0] d, input logic eig);
    logic [7:0] q;
    logic ok, ig;
    mfc_host_model_i.acc(1'b1, a, d, q, ok, ig);
    chk("write ready", 16'h0001, {15'h0000, ok});
    chk("write refused", {15'h0000, eig}, {15'h0000, ig});
  endtask
  // one frame summary, verdict {done,accept,long,pause} checked in the done cycle
  task automatic frm(input logic [15:0] c, l, input logic [4:0] f, input logic [3:0] e, input logic [15:0] k);
    @(negedge clk_sys_in);
    fe = 1'b1;
    cnt = c;
    lt = l;
    {bc, mc, am, hh, pz} = f;
    @(negedge clk_sys_in);
    fe = 1'b0;
    chk("rx verdict", {12'h000, e}, {12'h000, done, acc, lng, pind});
    chk("rx short", {15'h0000, c < MFC_MIN_FRAME}, {15'h0000, shrt});
    chk("rx keep", k, keep);
  endtask
  task automatic t_reset();
    rdb(MFC_ADDR_CTL_LO, 8'h00);
    rdb(MFC_ADDR_CTL_HI, 8'h00);
    rdb(MFC_ADDR_LIMIT_LO, 8'hEE);
    rdb(MFC_ADDR_LIMIT_HI, 8'h05);
    rdb(MFC_ADDR_GAP_LO, 8'h0C);
    rdb(MFC_ADDR_GAP_HI, 8'h00);
    rdb(8'h40, 8'h00);
  endtask
  task automatic t_write();
    wrb(MFC_ADDR_CTL_HI, 8'hFF, 1'b0);
    rdb(MFC_ADDR_CTL_HI, 8'h01);
    wrb(MFC_ADDR_GAP_LO, 8'hFF, 1'b0);
    rdb(MFC_ADDR_GAP_LO, 8'h1F);
    wrb(MFC_ADDR_CTL_HI, 8'h00, 1'b0);
    wrb(MFC_ADDR_LIMIT_LO, 8'h64, 1'b0);
    wrb(MFC_ADDR_LIMIT_HI, 8'h00, 1'b0);
    // long frames are still accepted, only tagged
    frm(16'd101, 16'h0800, 5'b00100, 4'b1110, 16'd101);
    frm(16'd100, 16'h0800, 5'b00100, 4'b1100, 16'd100);
  endtask
  // enabled MAC in either direction refuses writes
  task automatic t_protect();
    for (int i = 1; i < 3; i++) begin
      {tx_en, rx_en} = i[1:0];
      wrb(MFC_ADDR_LIMIT_LO, 8'h00, 1'b1);
      wrb(MFC_ADDR_CTL_LO, 8'hFF, 1'b1);
      rdb(MFC_ADDR_LIMIT_LO, 8'h64);
      rdb(MFC_ADDR_CTL_LO, 8'h00);
    end
    {tx_en, rx_en} = 2'b00;
    wrb(MFC_ADDR_LIMIT_LO, 8'hEE, 1'b0);
    wrb(MFC_ADDR_LIMIT_HI, 8'h05, 1'b0);
  endtask
  task automatic t_rx();
    frm(16'd60, 16'h0800, 5'b00100, 4'b1000, 16'd60);
    frm(16'd100, 16'h0800, 5'b10000, 4'b1000, 16'd100);
    frm(16'd100, 16'h0800, 5'b01010, 4'b1000, 16'd100);
    frm(16'd100, 16'h8808, 5'b01001, 4'b1100, 16'd100);
    frm(16'd1519, 16'h0800, 5'b00100, 4'b1110, 16'd1519);
    wrb(MFC_ADDR_CTL_LO, 8'hD9, 1'b0);
    wrb(MFC_ADDR_CTL_HI, 8'h01, 1'b0);
    frm(16'd60, 16'h0800, 5'b00000, 4'b1100, 16'd60);
    frm(16'd100, 16'h0800, 5'b10000, 4'b1100, 16'd100);
    frm(16'd100, 16'h0800, 5'b01010, 4'b1100, 16'd100);
    frm(16'd100, 16'h8808, 5'b01001, 4'b1001, 16'd100);
    wrb(MFC_ADDR_CTL_LO, 8'h02, 1'b0);
    wrb(MFC_ADDR_CTL_HI, 8'h00, 1'b0);
    frm(16'd64, 16'h0014, 5'b00100, 4'b1100, 16'd34);
    frm(16'd64, 16'h0800, 5'b00100, 4'b1100, 16'd60);
    frm(16'd100, 16'h002E, 5'b00100, 4'b1100, 16'd96);
  endtask
  task automatic t_tx();
    wrb(MFC_ADDR_CTL_LO, 8'h24, 1'b0);
    repeat (3) @(negedge clk_sys_in);
    chk("feature ctl", 16'h0024, fctl);
    chk("frame limit", 16'h05EE, flim);
    chk("half duplex", 16'h0001, {15'h0000, hdx});
    chk("append fcs", 16'h0000, {15'h0000, fcs});
    gbit = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    chk("half duplex gbit", 16'h0000, {15'h0000, hdx});
  endtask
  // gap of two byte times, second tick is the boundary
  task automatic t_gap();
    wrb(MFC_ADDR_GAP_LO, 8'h02, 1'b0);
    @(negedge clk_sys_in);
    tfe = 1'b1;
    @(negedge clk_sys_in);
    tfe = 1'b0;
    for (int i = 0; i < 2; i++) begin
      repeat (2) @(negedge clk_sys_in);
      chk("gap early", 16'h0000, {15'h0000, gok});
      tick = 1'b1;
      @(negedge clk_sys_in);
      tick = 1'b0;
    end
    chk("gap at done", 16'h0000, {15'h0000, gok});
    @(negedge clk_sys_in);
    chk("gap met", 16'h0001, {15'h0000, gok});
  endtask
  // watchdog well past the roughly one hundred cycles the run needs
  initial begin
    #200000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    {tx_en, rx_en, gbit, fe, bc, mc, am, hh, pz, tfe, tick} = 11'h000;
    cnt = 16'h0000;
    lt = 16'h0000;
    repeat (4) @(negedge clk_sys_in);
    rst_in = 1'b0;
    t_reset();
    t_write();
    t_protect();
    t_rx();
    t_tx();
    t_gap();
    give_verdict();
  end
endmodule
